// file: verilog/tm1_map.svh
`ifndef TM1_MAP_SVH
`define TM1_MAP_SVH

// register byte offsets on the bus
`define TM1_OFS_CTRL 8'h00
`define TM1_OFS_CNT_LO 8'h04
`define TM1_OFS_CNT_HI 8'h08
`define TM1_OFS_GATE 8'h0C
`define TM1_OFS_STATUS 8'h10

// control register fields
`define TM1_CTRL_SRC_HI 7
`define TM1_CTRL_SRC_LO 6
`define TM1_CTRL_PSC_HI 5
`define TM1_CTRL_PSC_LO 4
`define TM1_CTRL_OSCEN 3
`define TM1_CTRL_NOSYNC 2
`define TM1_CTRL_RUN 0
`define TM1_CTRL_RST 8'h00
`define TM1_CTRL_WMASK 8'hFD

// clock source codes
`define TM1_SRC_INSTR 2'h0
`define TM1_SRC_SYS 2'h1
`define TM1_SRC_EXT 2'h2
`define TM1_SRC_CAP 2'h3

// gate register fields
`define TM1_GATE_EN 7
`define TM1_GATE_VAL 2
`define TM1_GATE_RST 8'h00
`define TM1_GATE_WMASK 8'hFB

// status register: overflow flag, write one to clear
`define TM1_STAT_OVF 0

// instruction clock is the system clock divided by this
`define TM1_INSTR_DIV 4
`define TM1_INSTR_CNT_W 2

`endif

// file: verilog/tm1_pkg.sv
package tm1_pkg;

  // bus answer sequencing
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } tm1_bus_state_t;

  typedef logic [7:0] tm1_byte_t;
  typedef logic [15:0] tm1_count_t;

endpackage : tm1_pkg

// file: verilog/tm1_cnt_if.sv
`timescale 1ns/1ps

// ties the control block to the counting core
interface tm1_cnt_if;
  logic tick;
  logic run;
  logic [1:0] psc_sel;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wr_data;
  logic [15:0] count;
  logic ovf;

  modport ctrl (output tick, run, psc_sel, wr_lo, wr_hi, wr_data,
                input count, ovf);
  modport core (input tick, run, psc_sel, wr_lo, wr_hi, wr_data,
                output count, ovf);
endinterface : tm1_cnt_if

// file: verilog/tm1_pin_sync.sv
`timescale 1ns/1ps

// three-stage pin synchroniser with agreement filter and rise pulse
module tm1_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pin,
  output logic rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // the first stage feeds only the second, to let metastability settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else if (ce) begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= 1'b0;
    end else if (ce && (s2_ff == s3_ff)) begin
      level_ff <= s3_ff;
    end
  end

  assign rise = ce & s2_ff & s3_ff & ~level_ff;
endmodule : tm1_pin_sync

// file: verilog/tm1_count_core.sv
`timescale 1ns/1ps

// prescaler and sixteen-bit counter
module tm1_count_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  tm1_cnt_if.core cif
);
  import tm1_pkg::*;

  logic [2:0] psc_ff;
  logic [2:0] psc_mask;
  logic psc_done;
  tm1_count_t count_ff;
  logic ovf_ff;

  // divide by 1, 2, 4 or 8
  assign psc_mask = 3'((4'h1 << cif.psc_sel) - 4'h1);
  assign psc_done = ((psc_ff & psc_mask) == psc_mask);

  // prescaler restarts on any counter write so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_ff <= 3'h0;
    end else if (ce) begin
      if (cif.wr_lo || cif.wr_hi) begin
        psc_ff <= 3'h0;
      end else if (cif.run && cif.tick) begin
        psc_ff <= psc_done ? 3'h0 : 3'(psc_ff + 3'h1);
      end
    end
  end

  // counter steps on each prescaled tick while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 16'h0000;
      ovf_ff <= 1'b0;
    end else if (ce) begin
      ovf_ff <= 1'b0;
      if (cif.wr_lo) begin
        count_ff[7:0] <= cif.wr_data;
      end else if (cif.wr_hi) begin
        count_ff[15:8] <= cif.wr_data;
      end else if (cif.run && cif.tick && psc_done) begin
        count_ff <= 16'(count_ff + 16'h0001);
        ovf_ff <= (count_ff == 16'hFFFF);
      end
    end
  end

  assign cif.count = count_ff;
  assign cif.ovf = ovf_ff;
endmodule : tm1_count_core

// file: verilog/tm1_timer.sv
//
// Overview of operation
// - source code 11 counts capacitive oscillator
// - code 10, oscillator off: count pin rises
// - code 01 counts every system clock
// - code 00 counts instruction clock, quarter rate
// - prescale codes divide by 1,2,4,8
// - oscillator enable bit powers dedicated oscillator
// - external source, bit set: unsynchronised count
// - external source, bit clear: synchronise first
// - internal source ignores synchronisation bit
// - run bit starts and stops counter
// - run bit clear also clears gate flop
// - control bit 1 always reads zero
//
`timescale 1ns/1ps
`include "tm1_map.svh"

module tm1_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input_pin,
  input wire logic dedicated_osc_in,
  input wire logic cap_sense_oscillator,
  input wire logic gate_pin,
  output logic dedicated_osc_enable,
  output logic counter_overflow_flag,
  output tm1_pkg::tm1_count_t count_value
);
  import tm1_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  // bundle towards the counting core
  tm1_cnt_if cif ();

  // bus slave state and its registered answers
  tm1_bus_state_t bus_state_ff;
  tm1_bus_state_t nxt_bus_state;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  tm1_byte_t ctrl_ff;
  tm1_byte_t gate_ctrl_ff;
  logic gate_flop_ff;
  logic ovf_flag_ff;
  logic osc_en_ff;
  tm1_count_t count_out_ff;

  logic [`TM1_INSTR_CNT_W-1:0] instr_div_ff;
  logic instr_tick;
  logic ext_edge_sync_ff;

  logic [3:0] pin_in;
  logic [3:0] pin_rise;

  logic bus_access;
  logic bus_done;
  logic wr_done;
  logic rd_load;
  logic addr_hit;
  tm1_byte_t rd_byte;
  logic ext_edge;
  logic sel_tick;

  logic [1:0] src_sel;
  logic run_bit;
  logic osc_bit;
  logic nosync_bit;

  // ************************************************************
  // decode helpers
  // ************************************************************

  // true when the offset is one of the five mapped words
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == `TM1_OFS_CTRL) begin
      return 1'b1;
    end else if (a == `TM1_OFS_CNT_LO) begin
      return 1'b1;
    end else if (a == `TM1_OFS_CNT_HI) begin
      return 1'b1;
    end else if (a == `TM1_OFS_GATE) begin
      return 1'b1;
    end else if (a == `TM1_OFS_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  // a write to one offset in this cycle's completing access
  function automatic logic wr_at(input logic done, input logic [7:0] a,
                                 input logic [7:0] ofs);
    return done && (a == ofs);
  endfunction : wr_at

  // ************************************************************
  // control field views
  // ************************************************************
  // named views of the stored control fields
  assign src_sel = ctrl_ff[`TM1_CTRL_SRC_HI:`TM1_CTRL_SRC_LO];
  assign run_bit = ctrl_ff[`TM1_CTRL_RUN];
  assign osc_bit = ctrl_ff[`TM1_CTRL_OSCEN];
  assign nosync_bit = ctrl_ff[`TM1_CTRL_NOSYNC];

  // ************************************************************
  // bus slave
  // ************************************************************

  // every access takes one wait cycle so read data can come from a flop
  assign bus_access = psel && penable;
  assign bus_done = bus_access && pready_ff;
  assign wr_done = bus_done && pwrite;
  assign rd_load = bus_access && !pready_ff;
  assign addr_hit = is_mapped(paddr);

  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      BUS_IDLE: begin
        if (bus_access) begin
          nxt_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_ff <= BUS_IDLE;
    end else if (ce) begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // ready rises for exactly one cycle, the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= (nxt_bus_state == BUS_ANSWER);
      pslverr_ff <= (nxt_bus_state == BUS_ANSWER) && !addr_hit;
    end
  end

  // read mux; unused upper bits and unmapped offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (paddr == `TM1_OFS_CTRL) begin
      rd_byte = ctrl_ff & `TM1_CTRL_WMASK;
    end else if (paddr == `TM1_OFS_CNT_LO) begin
      rd_byte = cif.count[7:0];
    end else if (paddr == `TM1_OFS_CNT_HI) begin
      rd_byte = cif.count[15:8];
    end else if (paddr == `TM1_OFS_GATE) begin
      rd_byte = gate_ctrl_ff;
      rd_byte[`TM1_GATE_VAL] = gate_flop_ff;
    end else if (paddr == `TM1_OFS_STATUS) begin
      rd_byte[`TM1_STAT_OVF] = ovf_flag_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (rd_load && !pwrite) begin
        prdata_ff <= {24'h00_0000, rd_byte};
      end else if (bus_done) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************

  // control register; bit 1 never stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `TM1_CTRL_RST;
    end else if (ce && wr_at(wr_done, paddr, `TM1_OFS_CTRL)) begin
      ctrl_ff <= pwdata[7:0] & `TM1_CTRL_WMASK;
    end
  end

  // gate register storage; the value bit is the gate flop itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ctrl_ff <= `TM1_GATE_RST;
    end else if (ce && wr_at(wr_done, paddr, `TM1_OFS_GATE)) begin
      gate_ctrl_ff <= pwdata[7:0] & `TM1_GATE_WMASK;
    end
  end

  // gate flop toggles on gate pin rises; a stopped timer holds it clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_flop_ff <= 1'b0;
    end else if (ce) begin
      if (!run_bit) begin
        gate_flop_ff <= 1'b0;
      end else if (gate_ctrl_ff[`TM1_GATE_EN] && pin_rise[3]) begin
        gate_flop_ff <= !gate_flop_ff;
      end
    end
  end

  // overflow flag: a rollover in the clearing cycle keeps it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_ff <= 1'b0;
    end else if (ce) begin
      if (cif.ovf) begin
        ovf_flag_ff <= 1'b1;
      end else if (wr_at(wr_done, paddr, `TM1_OFS_STATUS) &&
                   pwdata[`TM1_STAT_OVF]) begin
        ovf_flag_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // count sources
  // ************************************************************

  // all outside sources pass a three-flop filter
  assign pin_in = {gate_pin, cap_sense_oscillator, dedicated_osc_in,
                   ext_count_input_pin};

  // one filter per outside line, so every source sees the same delay except the synchronised external path, one cycle later
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      tm1_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin(pin_in[gi]),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  // instruction clock: one tick in every four system clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div_ff <= '0;
    end else if (ce) begin
      instr_div_ff <= `TM1_INSTR_CNT_W'(instr_div_ff + 1'b1);
    end
  end
  // tick on the last count of each round of four
  assign instr_tick = (instr_div_ff == `TM1_INSTR_CNT_W'(`TM1_INSTR_DIV - 1));

  // pin when the oscillator is off, oscillator edges when it is on
  assign ext_edge = osc_bit ? pin_rise[1] : pin_rise[0];

  // synchronised mode re-times the edge to a system clock boundary,
  // costing one cycle of latency against the unsynchronised path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_edge_sync_ff <= 1'b0;
    end else if (ce) begin
      ext_edge_sync_ff <= ext_edge;
    end
  end

  // source select; internal codes never look at the sync bit
  always_comb begin
    sel_tick = 1'b0;
    case (src_sel)
      `TM1_SRC_INSTR: sel_tick = instr_tick;
      `TM1_SRC_SYS: sel_tick = 1'b1;
      `TM1_SRC_EXT: sel_tick = nosync_bit ? ext_edge
                                         : ext_edge_sync_ff;
      `TM1_SRC_CAP: sel_tick = pin_rise[2];
      default: sel_tick = 1'b0;
    endcase
  end

  // ************************************************************
  // counting core
  // ************************************************************
  // counter writes reach the core in the cycle the bus completes
  assign cif.tick = ce && sel_tick;
  assign cif.run = run_bit;
  assign cif.psc_sel = ctrl_ff[`TM1_CTRL_PSC_HI:`TM1_CTRL_PSC_LO];
  assign cif.wr_lo = wr_at(wr_done, paddr, `TM1_OFS_CNT_LO);
  assign cif.wr_hi = wr_at(wr_done, paddr, `TM1_OFS_CNT_HI);
  assign cif.wr_data = pwdata[7:0];

  // the core owns the prescaler and the counter itself
  tm1_count_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cif(cif)
  );

  // ************************************************************
  // registered outputs
  // ************************************************************

  // oscillator enable follows the control bit, one flop later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_ff <= 1'b0;
      count_out_ff <= 16'h0000;
    end else if (ce) begin
      osc_en_ff <= osc_bit;
      count_out_ff <= cif.count;
    end
  end

  // ports come straight from flops, with no logic behind them
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dedicated_osc_enable = osc_en_ff;
  assign counter_overflow_flag = ovf_flag_ff;
  assign count_value = count_out_ff;
endmodule : tm1_timer

// file: bench/tm1_src_model.sv
`timescale 1ns/1ps
// ************************************************************
// far-side count sources: pin, dedicated oscillator, cap osc
// ************************************************************
module tm1_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] en,
  output logic pin,
  output logic osc,
  output logic cap,
  output logic [2:0][15:0] rise
);
  // unequal half periods (4, 6, 5) so a wrong source choice shows up;
  // rises stay 8 or more cycles apart, above the synchroniser's need
  localparam logic [3:0] HALF [3] = '{4'h3, 4'h5, 4'h4};
  logic [2:0] line_ff;
  logic [3:0] div_ff [3];
  assign {cap, osc, pin} = line_ff;
  // a disabled line stands low; rises are counted for the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= 3'h0;
      rise <= '0;
      div_ff <= '{default: 4'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!en[i]) begin
          line_ff[i] <= 1'b0;
          div_ff[i] <= 4'h0;
        end else if (div_ff[i] == HALF[i]) begin
          div_ff[i] <= 4'h0;
          line_ff[i] <= ~line_ff[i];
          if (!line_ff[i]) rise[i] <= rise[i] + 16'h0001;
        end else begin
          div_ff[i] <= div_ff[i] + 4'h1;
        end
      end
    end
  end
endmodule : tm1_src_model

// file: bench/tm1_timer_checker.sv
`timescale 1ns/1ps
// ************************************************************
// port checker for the timer
// ************************************************************
module tm1_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_count_input_pin,
  input wire logic dedicated_osc_in,
  input wire logic cap_sense_oscillator,
  input wire logic dedicated_osc_enable,
  input wire logic counter_overflow_flag,
  input wire tm1_pkg::tm1_count_t count_value
);
  import tm1_pkg::*;
  logic [7:0] ctl_ff;
  logic [3:0] age_ff;
  logic [3:0] src_age_ff;
  logic sel_ff;
  logic sel;
  logic wr_done;
  logic rd_ctl;
  assign wr_done = ce && psel && penable && pready && pwrite && !pslverr;
  assign rd_ctl = ce && psel && penable && pready && !pwrite && paddr == 8'h00;
  assign sel = ctl_ff[6] ? cap_sense_oscillator :
    (ctl_ff[3] ? dedicated_osc_in : ext_count_input_pin);
  // shadow of control; age counts cycles since any error-free write or low ce, since a
  // write may move the counter or the setup under the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_ff <= 8'h00;
    else if (wr_done && paddr == 8'h00) ctl_ff <= pwdata[7:0] & 8'hFD;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_ff <= 4'h0;
    else if (wr_done || !ce) age_ff <= 4'h0;
    else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
  end
  // cycles since the selected source last rose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= 1'b0;
      src_age_ff <= 4'hF;
    end else begin
      sel_ff <= sel;
      if (sel && !sel_ff) src_age_ff <= 4'h0;
      else if (src_age_ff != 4'hF) src_age_ff <= src_age_ff + 4'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ctl_bit1_zero_a: assert property (
    rd_ctl |-> !prdata[1]) else $error("control bit 1 read as one");
  osc_follow_a: assert property (
    age_ff >= 4'h1 |-> dedicated_osc_enable == ctl_ff[3])
    else $error("oscillator enable not following control");
  sys_rate_a: assert property (
    age_ff >= 4'h4 && (ctl_ff & 8'hF1) == 8'h41
    |-> count_value == $past(count_value) + 16'h0001)
    else $error("system clock rate wrong");
  instr_rate_a: assert property (
    age_ff >= 4'h8 && (ctl_ff & 8'hF1) == 8'h01
    |-> count_value - $past(count_value, 4) == 16'h0001)
    else $error("instruction clock rate wrong");
  psc_half_a: assert property (
    age_ff >= 4'h8 && (ctl_ff & 8'hF1) == 8'h51
    |-> count_value - $past(count_value, 2) == 16'h0001)
    else $error("divide by two wrong");
  psc_eighth_a: assert property (
    age_ff >= 4'hC && (ctl_ff & 8'hF1) == 8'h71
    |-> count_value - $past(count_value, 8) == 16'h0001)
    else $error("divide by eight wrong");
  run_stop_a: assert property (
    age_ff >= 4'h3 && !ctl_ff[0] |-> $stable(count_value))
    else $error("counter moved while stopped");
  ext_cause_a: assert property (
    age_ff >= 4'h3 && ctl_ff[7] && count_value != $past(count_value)
    |-> src_age_ff == ((ctl_ff[7:6] == 2'b10 && !ctl_ff[2]) ? 4'h5 : 4'h4))
    else $error("count without source edge");
  ovf_set_a: assert property (
    $past(count_value) == 16'hFFFF && count_value == 16'h0000
    |-> ##[0:2] counter_overflow_flag) else $error("overflow flag missed");
  ovf_cause_a: assert property (
    $rose(counter_overflow_flag) |-> count_value <= 16'h0002)
    else $error("overflow flag without rollover");
endmodule : tm1_chk

bind tm1_timer tm1_chk i_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .ext_count_input_pin, .dedicated_osc_in, .cap_sense_oscillator,
  .dedicated_osc_enable, .counter_overflow_flag, .count_value);

// file: bench/testbench.sv
`timescale 1ns/1ps
// ************************************************************
// testbench for the timer
// ************************************************************
module testbench;
  import tm1_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic gate_pin = 1'b0;
  logic ce = 1'b1;
  logic [2:0] en = 3'h0;
  logic [31:0] prdata, rd, lo;
  logic pready, pslverr, err, pin, osc, cap, osc_en, ovf;
  logic [2:0][15:0] rise;
  logic [15:0] r0;
  tm1_count_t count_value;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] cfg [6] = '{8'h81, 8'h85, 8'h89, 8'hC1, 8'h91, 8'hB5};
  int lns [6] = '{0, 0, 1, 2, 0, 0};
  logic [7:0] icfg [5] = '{8'h41, 8'h45, 8'h51, 8'h71, 8'h01};
  always #5 pclk = ~pclk;
  tm1_timer i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_count_input_pin(pin), .dedicated_osc_in(osc),
    .cap_sense_oscillator(cap), .gate_pin, .dedicated_osc_enable(osc_en),
    .counter_overflow_flag(ovf), .count_value);
  tm1_src_model i_src (.pclk, .presetn, .en, .pin, .osc, .cap, .rise);
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle cycle follows so strobes never re-assert
  // in the same step they were released
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the hang guard ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // all three sources toggle; only the selected one may reach the count
  task ext(input logic [7:0] c, input int ln);
    wr(8'h00, c & 8'hFE);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h00, c);
    r0 = rise[ln];
    en <= 3'h7;
    idle(200);
    en <= 3'h0;
    idle(20);
    apb(1'b0, 8'h04, 32'h0);
    lo = rd;
    apb(1'b0, 8'h08, 32'h0);
    r0 = 16'(rise[ln] - r0) >> c[5:4];
    chk({16'h0000, rd[7:0], lo[7:0]}, {16'h0000, r0});
  endtask : ext
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h10, 32'h0);
    wr(8'h00, 8'hFE);
    rdc(8'h00, 32'hFC);
    chk({31'h0, osc_en}, 32'h1);
    wr(8'h00, 8'h00);
    idle(2);
    chk({31'h0, osc_en}, 32'h0);
    $display("test registers finished");
    for (int i = 0; i < 6; i++) ext(cfg[i], lns[i]);
    $display("test external sources finished");
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, icfg[i]);
      idle(40);
      wr(8'h00, icfg[i] & 8'hFE);
      idle(4);
      apb(1'b0, 8'h04, 32'h0);
      lo = rd;
      idle(10);
      rdc(8'h04, lo);
    end
    // a low clock enable must freeze the running count
    wr(8'h00, 8'h41);
    ce <= 1'b0;
    idle(2);
    r0 = count_value;
    idle(20);
    chk({16'h0000, count_value}, {16'h0000, r0});
    ce <= 1'b1;
    wr(8'h00, 8'h40);
    $display("test internal sources finished");
    wr(8'h04, 8'hF0);
    wr(8'h08, 8'hFF);
    wr(8'h10, 8'h01);
    rdc(8'h10, 32'h0);
    wr(8'h00, 8'h41);
    idle(30);
    wr(8'h00, 8'h40);
    rdc(8'h10, 32'h1);
    wr(8'h10, 8'h01);
    rdc(8'h10, 32'h0);
    $display("test overflow finished");
    wr(8'h0C, 8'h80);
    wr(8'h00, 8'h01);
    gate_pin <= 1'b1;
    idle(8);
    gate_pin <= 1'b0;
    idle(8);
    rdc(8'h0C, 32'h84);
    wr(8'h00, 8'h00);
    rdc(8'h0C, 32'h80);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test gate and unmapped finished");
    final_report;
  end
endmodule : testbench
